// ### hdl/zoned_release_controller.sv
`timescale 1ns/1ps
module zoned_release_controller #(
	parameter logic [31:0] DELAY_RESET_CYCLES =
		release_pkg::DEFAULT_DELAY_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [18:0] pins,    // raw panel inputs, see package
	output logic             release_out,
	output logic             predischarge_led,
	output logic             predischarge_relay,
	output logic             zone1_relay,
	output logic             zone2_relay,
	output logic             zone1_led,
	output logic             zone2_led,
	output logic             general_alarm_relay,
	output logic             audible_alarm_out,
	output logic             trouble_led,
	output logic             trouble_buzzer,
	output logic             general_trouble_out,
	output logic             power_led
);
	////////////////////////////////////////////////////////////////////
	// input synchronisers and zoning decode

	logic [18:0]          sy;        // synchronised pins
	release_pkg::mode_t   mode;      // decoded zoning mode

	pin_sync #(.W(release_pkg::PIN_W)) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (pins),
		.q     (sy)
	);

	// jumper decode
	// installed jumper reads as one; a and b both out is unauthorised
	function automatic release_pkg::mode_t decode_mode(
		input logic a, input logic b, input logic c);
		if (!a && !b)
			return release_pkg::MODE_UNAUTH;
		else if (!a)
			return release_pkg::MODE_Z1_PRI;
		else if (!b)
			return release_pkg::MODE_Z2_PRI;
		else if (!c)
			return release_pkg::MODE_CROSS;
		else
			return release_pkg::MODE_SINGLE;
	endfunction

	assign mode = decode_mode(sy[release_pkg::PIN_JMP_A],
		sy[release_pkg::PIN_JMP_B], sy[release_pkg::PIN_JMP_C]);

	////////////////////////////////////////////////////////////////////
	// apb register file

	logic [3:0]  ctrl_q, ctrl_d;     // control bits
	logic [31:0] delay_q, delay_d;   // release delay in cycles
	logic [31:0] prdata_d;
	logic        pready_d, pslverr_d;
	logic        sw_rst_q, sw_rst_d; // one-cycle software panel reset
	logic        wr_en;
	logic        hit;
	logic [31:0] status;

	// one wait state: pready rises on the second access cycle
	assign wr_en = psel && penable && pready && pwrite;
	assign hit   = (paddr == release_pkg::ADDR_CTRL)
	            || (paddr == release_pkg::ADDR_DELAY)
	            || (paddr == release_pkg::ADDR_STATUS);

	// register writes and read mux
	always_comb begin
		ctrl_d    = ctrl_q;
		delay_d   = delay_q;
		sw_rst_d  = 1'b0;
		pready_d  = psel && penable && !pready;
		pslverr_d = psel && penable && !pready && !hit;
		prdata_d  = '0;
		if (wr_en && paddr == release_pkg::ADDR_CTRL) begin
			ctrl_d   = pwdata[3:0];
			sw_rst_d = pwdata[release_pkg::CTRL_PANEL_RST];
		end
		if (wr_en && paddr == release_pkg::ADDR_DELAY) begin
			delay_d = pwdata;
		end
		if (psel && penable && !pready && !pwrite) begin
			unique case (paddr)
				release_pkg::ADDR_CTRL:   prdata_d = {28'h0, ctrl_q};
				release_pkg::ADDR_DELAY:  prdata_d = delay_q;
				release_pkg::ADDR_STATUS: prdata_d = status;
				default:                  prdata_d = '0;
			endcase
		end
	end

	// bus registers, control defaults to abort and aux unused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q   <= release_pkg::CTRL_RESET;
			delay_q  <= DELAY_RESET_CYCLES;
			sw_rst_q <= 1'b0;
			prdata   <= '0;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			delay_q  <= delay_d;
			sw_rst_q <= sw_rst_d;
			prdata   <= prdata_d;
			pready   <= pready_d;
			pslverr  <= pslverr_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// zone latches and release sequence

	logic                panel_rst;
	logic                abort_act;
	logic [1:0]          zl_q, zl_d;    // latched zone alarms
	release_pkg::state_t st_q, st_d;
	logic                fire;          // zoning says release
	logic                tmr_start;
	logic [31:0]         tmr_cnt;
	logic                tmr_done;

	assign panel_rst = sy[release_pkg::PIN_PRST] || sw_rst_q;
	// abort only counts when its circuit is in use
	assign abort_act = sy[release_pkg::PIN_ABORT]
	                && ctrl_q[release_pkg::CTRL_ABORT_USED];
	// status word: zoning mode, sequence state and latched zones
	assign status = {25'h0, mode, st_q, zl_q};

	// zoning combines latched zones so cross-zone may arrive apart
	always_comb begin
		unique case (mode)
			release_pkg::MODE_SINGLE: fire = |zl_q;
			release_pkg::MODE_Z1_PRI: fire = zl_q[0];
			release_pkg::MODE_Z2_PRI: fire = zl_q[1];
			release_pkg::MODE_CROSS:  fire = &zl_q;
			release_pkg::MODE_UNAUTH: fire = |zl_q;
			default:                  fire = 1'b0;
		endcase
	end

	// sequence next state; latches clear only on panel reset
	always_comb begin
		// latch zones
		// a live zone alarm wins over a panel reset in the same cycle
		zl_d      = (panel_rst ? 2'b00 : zl_q)
		          | {sy[release_pkg::PIN_Z2_ALM], sy[release_pkg::PIN_Z1_ALM]};
		st_d      = st_q;
		tmr_start = 1'b0;
		if (panel_rst) begin
			st_d = release_pkg::ST_IDLE;
		end else begin
			unique case (st_q)
				release_pkg::ST_IDLE: begin
					if (fire && mode == release_pkg::MODE_UNAUTH) begin
						st_d = release_pkg::ST_RELEASE;
					end else if (fire) begin
						st_d      = release_pkg::ST_DELAY;
						tmr_start = 1'b1;
					end
				end
				release_pkg::ST_DELAY: begin
					if (abort_act)
						st_d = release_pkg::ST_ABORT;
					else if (tmr_done)
						st_d = release_pkg::ST_RELEASE;
				end
				release_pkg::ST_ABORT: begin
					if (!abort_act && ctrl_q[release_pkg::CTRL_RESTART]) begin
						st_d      = release_pkg::ST_DELAY;
						tmr_start = 1'b1;
					end else if (!abort_act) begin
						st_d = release_pkg::ST_RELEASE;
					end
				end
				release_pkg::ST_RELEASE: st_d = release_pkg::ST_RELEASE;
			endcase
		end
	end

	release_timer u_timer (
		.clk    (pclk),
		.rst_n  (presetn),
		.start  (tmr_start),
		.stop   (panel_rst),
		.hold   (abort_act),
		.limit  (delay_q),
		.cnt_q  (tmr_cnt),
		.done_q (tmr_done)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zl_q <= 2'b00;
			st_q <= release_pkg::ST_IDLE;
		end else begin
			zl_q <= zl_d;
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs, alarm and trouble

	logic out_rel_d, out_pre_d, out_ga_d, out_aud_d, out_tr_d, out_bz_d;
	logic alarm, ga_jmp;

	assign ga_jmp = sy[release_pkg::PIN_JMP_GA];
	// general alarm input is an alarm condition
	assign alarm  = |zl_q || sy[release_pkg::PIN_GEN_IN]
	             || sy[release_pkg::PIN_PRESS];

	always_comb begin
		out_rel_d = (st_d == release_pkg::ST_RELEASE);
		out_pre_d = (st_d != release_pkg::ST_IDLE);
		// general alarm relay: latched zones always, general alarm input and pressure switch gated by jumper
		out_ga_d  = |zl_q || (ga_jmp && (sy[release_pkg::PIN_GEN_IN]
		          || sy[release_pkg::PIN_PRESS]));
		out_aud_d = alarm && !sy[release_pkg::PIN_ASIL];
		out_tr_d  = sy[release_pkg::PIN_Z1_OPEN] || sy[release_pkg::PIN_Z2_OPEN]
		         || sy[release_pkg::PIN_AUD_OPN] || sy[release_pkg::PIN_REL_OPN]
		         || (sy[release_pkg::PIN_ABT_OPN]
		             && ctrl_q[release_pkg::CTRL_ABORT_USED])
		         || (sy[release_pkg::PIN_AUX1_OP]
		             && ctrl_q[release_pkg::CTRL_AUX1_EN])
		         || (sy[release_pkg::PIN_AUX2_OP]
		             && ctrl_q[release_pkg::CTRL_AUX2_EN])
		         || sy[release_pkg::PIN_TSIL] || sy[release_pkg::PIN_ASIL];
		// buzzer is the only thing trouble silence mutes
		out_bz_d  = out_tr_d && !sy[release_pkg::PIN_TSIL];
	end

	// every output straight from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			release_out         <= 1'b0;
			predischarge_led    <= 1'b0;
			predischarge_relay  <= 1'b0;
			zone1_relay         <= 1'b0;
			zone2_relay         <= 1'b0;
			zone1_led           <= 1'b0;
			zone2_led           <= 1'b0;
			general_alarm_relay <= 1'b0;
			audible_alarm_out   <= 1'b0;
			trouble_led         <= 1'b0;
			trouble_buzzer      <= 1'b0;
			general_trouble_out <= 1'b0;
			power_led           <= 1'b0;
		end else begin
			release_out         <= out_rel_d;
			predischarge_led    <= out_pre_d;
			predischarge_relay  <= out_pre_d;
			zone1_relay         <= zl_q[0];
			zone2_relay         <= zl_q[1];
			zone1_led           <= zl_q[0];
			zone2_led           <= zl_q[1];
			general_alarm_relay <= out_ga_d;
			audible_alarm_out   <= out_aud_d;
			trouble_led         <= out_tr_d;
			trouble_buzzer      <= out_bz_d;
			general_trouble_out <= out_tr_d;
			power_led           <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_single;
		st_q == release_pkg::ST_IDLE && mode == release_pkg::MODE_SINGLE
		&& zl_q != 2'b00 && !panel_rst |=> st_q == release_pkg::ST_DELAY;
	endproperty
	a_single: assert property (p_single) else $error("single zone");

	property p_predis;
		st_q == release_pkg::ST_DELAY |-> predischarge_led
		&& predischarge_relay;
	endproperty
	a_predis: assert property (p_predis) else $error("predischarge");

	property p_prio;
		st_q == release_pkg::ST_IDLE && mode == release_pkg::MODE_Z1_PRI
		&& zl_q == 2'b10 |=> st_q == release_pkg::ST_IDLE;
	endproperty
	a_prio: assert property (p_prio) else $error("priority zone");

	property p_cross;
		st_q == release_pkg::ST_IDLE && mode == release_pkg::MODE_CROSS
		&& zl_q != 2'b11 |=> st_q == release_pkg::ST_IDLE;
	endproperty
	a_cross: assert property (p_cross) else $error("cross zone");

	property p_unauth;
		st_q == release_pkg::ST_IDLE && mode == release_pkg::MODE_UNAUTH
		&& zl_q != 2'b00 && !panel_rst |=> release_out;
	endproperty
	a_unauth: assert property (p_unauth) else $error("unauth");

	property p_abort;
		(st_q == release_pkg::ST_DELAY || st_q == release_pkg::ST_ABORT)
		&& abort_act |=> !release_out;
	endproperty
	a_abort: assert property (p_abort) else $error("abort leak");

	property p_restart;
		st_q == release_pkg::ST_ABORT && !abort_act && !panel_rst
		&& ctrl_q[release_pkg::CTRL_RESTART] |=> tmr_cnt == 32'h0;
	endproperty
	a_restart: assert property (p_restart) else $error("restart");

	property p_trouble;
		(sy[release_pkg::PIN_Z1_OPEN] || sy[release_pkg::PIN_Z2_OPEN]
		|| sy[release_pkg::PIN_AUD_OPN] || sy[release_pkg::PIN_REL_OPN])
		&& !sy[release_pkg::PIN_TSIL] |=> trouble_led && trouble_buzzer;
	endproperty
	a_trouble: assert property (p_trouble) else $error("trouble");

	property p_asil;
		sy[release_pkg::PIN_ASIL] |=> !audible_alarm_out && trouble_led;
	endproperty
	a_asil: assert property (p_asil) else $error("alarm silence");

	property p_latch;
		zl_q[0] && !panel_rst |=> zl_q[0] ##1 zone1_relay;
	endproperty
	a_latch: assert property (p_latch) else $error("zone latch");

	c_release: cover property (st_q == release_pkg::ST_DELAY
		##1 st_q == release_pkg::ST_RELEASE);
	c_abort:   cover property (st_q == release_pkg::ST_ABORT
		##1 st_q == release_pkg::ST_DELAY);
	c_cross:   cover property (mode == release_pkg::MODE_CROSS
		&& zl_q == 2'b11);
endmodule

// ### hdl/release_pkg.sv
package release_pkg;

	// clock and release delay timing
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned DEFAULT_DELAY_S = 30;
	localparam logic [31:0] DEFAULT_DELAY_CYC =
		32'(CLK_HZ * DEFAULT_DELAY_S);

	// apb register byte offsets
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_DELAY  = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;

	// control register fields
	localparam int CTRL_ABORT_USED = 0;
	localparam int CTRL_RESTART    = 1;
	localparam int CTRL_AUX1_EN    = 2;
	localparam int CTRL_AUX2_EN    = 3;
	localparam int CTRL_PANEL_RST  = 4;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// synchronised pin vector positions
	localparam int PIN_Z1_ALM  = 0;
	localparam int PIN_Z2_ALM  = 1;
	localparam int PIN_Z1_OPEN = 2;
	localparam int PIN_Z2_OPEN = 3;
	localparam int PIN_AUD_OPN = 4;
	localparam int PIN_REL_OPN = 5;
	localparam int PIN_ABT_OPN = 6;
	localparam int PIN_AUX1_OP = 7;
	localparam int PIN_AUX2_OP = 8;
	localparam int PIN_ABORT   = 9;
	localparam int PIN_GEN_IN  = 10;
	localparam int PIN_PRESS   = 11;
	localparam int PIN_TSIL    = 12;
	localparam int PIN_ASIL    = 13;
	localparam int PIN_PRST    = 14;
	localparam int PIN_JMP_A   = 15;
	localparam int PIN_JMP_B   = 16;
	localparam int PIN_JMP_C   = 17;
	localparam int PIN_JMP_GA  = 18;
	localparam int PIN_W       = 19;

	// zoning modes decoded from the jumpers
	typedef enum logic [2:0] {
		MODE_SINGLE = 3'b000,
		MODE_Z1_PRI = 3'b001,
		MODE_Z2_PRI = 3'b010,
		MODE_CROSS  = 3'b011,
		MODE_UNAUTH = 3'b100
	} mode_t;

	// release sequence states
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_DELAY   = 2'b01,
		ST_ABORT   = 2'b10,
		ST_RELEASE = 2'b11
	} state_t;

endpackage

// ### hdl/pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of independent pin levels
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;  // first stage, read only by second
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	// next values are plain shifts
	always_comb begin
		meta_d = d;
		q_d    = meta_q;
	end

	// both stages clear to inactive
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= meta_d;
			q      <= q_d;
		end
	end
endmodule

// ### hdl/release_timer.sv
`timescale 1ns/1ps
// release delay counter: counts cycles up to a loaded limit
module release_timer (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        start,   // begin or restart from zero
	input  wire logic        stop,    // panel reset clears it
	input  wire logic        hold,    // freeze while aborted
	input  wire logic [31:0] limit,   // delay in clock cycles
	output logic      [31:0] cnt_q,
	output logic             done_q
);
	logic        run_q;
	logic        run_d;
	logic [31:0] cnt_d;
	logic        done_d;

	// count while running and not held, flag when limit is reached
	always_comb begin
		run_d  = run_q;
		cnt_d  = cnt_q;
		done_d = done_q;
		if (stop) begin
			run_d  = 1'b0;
			cnt_d  = '0;
			done_d = 1'b0;
		end else if (start) begin
			run_d  = 1'b1;
			cnt_d  = '0;
			done_d = 1'b0;
		end else if (run_q && !hold && !done_q) begin
			cnt_d  = cnt_q + 32'h0000_0001;
			done_d = (cnt_d >= limit);
		end
	end

	// counter resets idle at zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q  <= 1'b0;
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else begin
			run_q  <= run_d;
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end
endmodule

// ### verif/panel_model.sv
`timescale 1ns/1ps
////////////////////////////////////////
// stand-in for detectors, switches, jumpers and field circuits
module panel_model (
	input  wire logic        clk,
	input  wire logic [18:0] want,  // levels asked for by the bench
	output logic      [18:0] pins   // levels seen at the panel terminals
);
	// the bench asks for every jumper fitted from time zero
	// contacts move just after an edge, never on the sampling instant
	always @(posedge clk) begin
		pins <= want;
	end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam int D  = 12;               // delay written at run time
	localparam int Z1 = release_pkg::PIN_Z1_ALM;
	localparam int Z2 = release_pkg::PIN_Z2_ALM;
	localparam int AB = release_pkg::PIN_ABORT;
	localparam int GA = release_pkg::PIN_GEN_IN;
	localparam int AS = release_pkg::PIN_ASIL;
	localparam int JG = release_pkg::PIN_JMP_GA;
	localparam logic [11:0] CT = release_pkg::ADDR_CTRL;
	localparam logic [11:0] DL = release_pkg::ADDR_DELAY;
	localparam logic [12:0] M  = 13'h1EFF; // audible left out

	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	wire  [31:0] prdata;
	wire         pready, pslverr;
	logic [18:0] want;   // requested panel levels
	wire  [18:0] pins;
	wire  [12:0] outs;   // all panel outputs, release in bit 0
	logic        err;
	int          bad_count, tests_run, n;

	panel_model pm (.clk(pclk), .want(want), .pins(pins));

	zoned_release_controller #(.DELAY_RESET_CYCLES(32'h14)) dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
		.release_out(outs[0]), .predischarge_led(outs[1]),
		.predischarge_relay(outs[2]), .zone1_relay(outs[3]),
		.zone2_relay(outs[4]), .zone1_led(outs[5]), .zone2_led(outs[6]),
		.general_alarm_relay(outs[7]), .audible_alarm_out(outs[8]),
		.trouble_led(outs[9]), .trouble_buzzer(outs[10]),
		.general_trouble_out(outs[11]), .power_led(outs[12]));

	// free running 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; waits for pready with a bounded count
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		if (k >= 20) begin
			bad_count++;
		end
	endtask

	task tick(input int c);
		repeat (c) @(posedge pclk);
	endtask

	task setp(input int i, input logic v);
		@(posedge pclk);
		want[i] <= v;
	endtask

	// bounded wait for one output bit; n holds cycles spent
	task waitb(input int b, input int lim);
		n = 0;
		while (outs[b] !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask

	// software panel reset keeping control bits c
	task prst(input logic [31:0] c);
		tick(3);
		apb(1'h1, CT, c | 32'h10);
		tick(4);
	endtask

	// raise one zone and look at the release output after a long wait
	task zone_try(input int z, input logic rel);
		setp(z, 1'h1);
		tick(D + 20);
		chk(outs[0], rel);
	endtask

	task clear_zones;
		setp(Z1, 1'h0);
		setp(Z2, 1'h0);
	endtask

	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// watchdog well above the few hundred cycles the run needs
	initial begin
		#(100 * 20000);
		bad_count++;
		end_of_test;
	end

	////////////////////////////////////////
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		want = 19'h78000;
		presetn = 1'h0;
		bad_count = 0;
		tests_run = 0;
		tick(8);
		presetn <= 1'h1;
		tick(3);
		chk(outs, 32'h1000);
		apb(1'h0, CT, 32'h0);
		chk(rd, 32'h0);
		apb(1'h0, DL, 32'h0);
		chk(rd, 32'h14);
		apb(1'h0, 12'h00C, 32'h0);
		chk(rd, 32'h0);
		chk(err, 1'h1);
		apb(1'h1, DL, D);
		apb(1'h0, DL, 32'h0);
		chk(rd, D);
		// single zone mode, zone 1 then zone 2
		setp(Z1, 1'h1);
		waitb(1, 20);
		chk(outs[2:1], 2'h3);
		waitb(0, D + 10);
		chk(n >= D - 1 && n <= D + 3, 1'h1);
		chk(outs & M, 32'h10AF);
		// status: single mode, release state, zone 1 latched
		apb(1'h0, release_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h0000_000D);
		setp(Z1, 1'h0);
		tick(5);
		chk(outs & M, 32'h10AF);
		setp(release_pkg::PIN_PRST, 1'h1);
		setp(release_pkg::PIN_PRST, 1'h0);
		tick(5);
		chk(outs & M, 32'h1000);
		zone_try(Z2, 1'h1);
		clear_zones;
		prst(32'h0);
		// zone 1 priority, then zone 2 priority
		setp(release_pkg::PIN_JMP_A, 1'h0);
		zone_try(Z2, 1'h0);
		chk(outs & M, 32'h10D0);
		zone_try(Z1, 1'h1);
		clear_zones;
		prst(32'h0);
		setp(release_pkg::PIN_JMP_A, 1'h1);
		setp(release_pkg::PIN_JMP_B, 1'h0);
		zone_try(Z1, 1'h0);
		zone_try(Z2, 1'h1);
		clear_zones;
		prst(32'h0);
		// cross zoned: one zone latched, second completes it
		setp(release_pkg::PIN_JMP_B, 1'h1);
		setp(release_pkg::PIN_JMP_C, 1'h0);
		zone_try(Z1, 1'h0);
		chk(outs & M, 32'h10A8);
		zone_try(Z2, 1'h1);
		chk(outs & M, 32'h10FF);
		clear_zones;
		prst(32'h0);
		// unauthorised setting fires with no delay
		setp(release_pkg::PIN_JMP_A, 1'h0);
		setp(release_pkg::PIN_JMP_B, 1'h0);
		setp(release_pkg::PIN_JMP_C, 1'h1);
		setp(Z1, 1'h1);
		waitb(0, 8);
		// model, two sync stages, latch and state: six edges, no delay
		chk(n <= 6, 1'h1);
		clear_zones;
		prst(32'h0);
		setp(release_pkg::PIN_JMP_A, 1'h1);
		setp(release_pkg::PIN_JMP_B, 1'h1);
		// abort then fire at once
		apb(1'h1, CT, 32'h1);
		setp(Z1, 1'h1);
		waitb(1, 20);
		setp(AB, 1'h1);
		tick(D + 10);
		chk(outs[0], 1'h0);
		setp(AB, 1'h0);
		waitb(0, 6);
		chk(outs[0], 1'h1);
		clear_zones;
		prst(32'h1);
		// abort then a full fresh delay
		apb(1'h1, CT, 32'h3);
		setp(Z1, 1'h1);
		waitb(1, 20);
		tick(D / 2);
		setp(AB, 1'h1);
		tick(D + 10);
		chk(outs[0], 1'h0);
		setp(AB, 1'h0);
		waitb(0, D + 10);
		// six edges of pipeline plus a full delay counted from zero
		chk(n >= D + 4 && n <= D + 8, 1'h1);
		clear_zones;
		prst(32'h3);
		// supervised opens with abort and both aux loops in use
		apb(1'h1, CT, 32'hD);
		for (int i = release_pkg::PIN_Z1_OPEN; i <= 8; i++) begin
			setp(i, 1'h1);
			tick(5);
			chk(outs[10:9], 2'h3);
			setp(i, 1'h0);
			tick(5);
			chk(outs[10:9], 2'h0);
		end
		// unused abort and aux circuits are not supervised
		apb(1'h1, CT, 32'h0);
		for (int i = release_pkg::PIN_ABT_OPN; i <= 8; i++) begin
			setp(i, 1'h1);
			tick(5);
			chk(outs[10:9], 2'h0);
			setp(i, 1'h0);
		end
		setp(release_pkg::PIN_TSIL, 1'h1);
		tick(5);
		chk({outs[11], outs[9]}, 2'h3);
		chk(outs[10], 1'h0);
		setp(release_pkg::PIN_TSIL, 1'h0);
		setp(AS, 1'h1);
		tick(5);
		chk(outs[9], 1'h1);
		setp(AS, 1'h0);
		// general alarm input and pressure switch, both jumper settings
		setp(GA, 1'h1);
		tick(5);
		chk(outs[8:7], 2'h3);
		setp(AS, 1'h1);
		tick(5);
		chk(outs[8], 1'h0);
		setp(AS, 1'h0);
		setp(JG, 1'h0);
		tick(5);
		chk(outs[8:7], 2'h2);
		setp(GA, 1'h0);
		setp(release_pkg::PIN_PRESS, 1'h1);
		tick(5);
		chk(outs[8:7], 2'h2);
		setp(JG, 1'h1);
		tick(5);
		chk(outs[8:7], 2'h3);
		setp(release_pkg::PIN_PRESS, 1'h0);
		prst(32'h0);
		chk(outs, 32'h1000);
		end_of_test;
	end
endmodule
